// file: shared/elg_map.svh
/*
  Offsets, field positions and reset values of the eight-level interrupt group block.
  Assumes a 32-bit AXI4-Lite slave with 8-bit byte addresses, one aligned word per register.
*/
`ifndef ELG_MAP_SVH
`define ELG_MAP_SVH

// ==========================================================================
// Register offsets
`define ELG_G1_CMD_OFS 8'h00
`define ELG_G1_DATA_OFS 8'h04
`define ELG_G2_CMD_OFS 8'h08
`define ELG_G2_DATA_OFS 8'h0C
`define ELG_ARM_OFS 8'h10
`define ELG_SVC_CLR_OFS 8'h14
`define ELG_ACK_STAT_OFS 8'h18

// ==========================================================================
// Fields and reset values
`define ELG_OP_MSB 7
`define ELG_OP_LSB 3
`define ELG_SEL_MSB 2
`define ELG_SOFT_RESET_CMD 8'h00
`define ELG_MASK_RESET 8'hFF
`define ELG_BYTE_ZERO 8'h00
`define ELG_BYTE_ONES 8'hFF
`define ELG_RESP_OKAY 2'b00
`define ELG_RESP_SLVERR 2'b10

`endif

// file: shared/elg_pkg.sv
/*
  Types shared by the interrupt group block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package elg_pkg;

  typedef struct packed {
    logic [7:0] in_service_reg;
    logic [7:0] auto_clear_select_reg;
    logic [7:0] request_mask_reg;
    logic [7:0] request_latch_reg;
  } elg_group_t;

  typedef struct packed {
    logic valid;
    logic group;
    logic [2:0] level;
  } elg_ack_t;

  typedef enum logic [4:0] {
    ELG_OP_CLR_BOTH_ALL = 5'b00010,
    ELG_OP_CLR_BOTH_ONE = 5'b00011,
    ELG_OP_UNMASK_ALL = 5'b00100,
    ELG_OP_UNMASK_ONE = 5'b00101,
    ELG_OP_MASK_ALL = 5'b00110,
    ELG_OP_MASK_ONE = 5'b00111,
    ELG_OP_DROP_ALL = 5'b01000,
    ELG_OP_DROP_ONE = 5'b01001,
    ELG_OP_RAISE_ALL = 5'b01010,
    ELG_OP_RAISE_ONE = 5'b01011
  } elg_op_t;

  typedef enum logic [1:0] {
    ELG_ACK_IDLE = 2'b00,
    ELG_ACK_GRANT = 2'b01,
    ELG_ACK_PASS = 2'b10
  } elg_ack_state_t;

endpackage

// file: logic/elg_sync_edge.sv
/*
  Three-stage synchroniser with a filtered level and a rising-edge pulse.
  Assumes an input asynchronous to core_clk.
*/
`timescale 1ns/1ps
module elg_sync_edge (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic level,
  output logic rise
);
  logic s1;
  logic s2;
  logic s3;

  // ==========================================================================
  // Stages
  // A change counts only once the second and third stages agree.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= 1'b0;
      rise <= 1'b0;
    end else begin
      if (s2 == s3) begin
        level <= s3;
      end
      rise <= (s2 == s3) && s3 && !level;
    end
  end
endmodule // elg_sync_edge

// file: logic/elg_irq_groups.sv
/*
  Two eight-level interrupt groups behind an AXI4-Lite slave, with an acknowledge chain.
  Assumes request pins and the acknowledge pin are asynchronous to core_clk.
*/
`timescale 1ns/1ps
`include "elg_map.svh"
module elg_irq_groups (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [15:0] irq_in,
  input wire logic ack_chain_input_n,
  output logic group_request_output,
  output logic ack_chain_pass,
  output elg_pkg::elg_ack_t ack_answer,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ==========================================================================
  // Declarations
  elg_pkg::elg_group_t grp [2];
  elg_pkg::elg_group_t next_grp [2];
  elg_pkg::elg_ack_state_t ack_state;
  elg_pkg::elg_ack_state_t next_ack_state;
  logic [1:0] group_arm_bit;
  logic [1:0] eff_arm;
  logic [15:0] irq_rise;
  logic [15:0] service_all;
  logic [15:0] fenced;
  logic [15:0] cand;
  logic [3:0] pick;
  logic ack_level;
  logic ack_start;
  logic grant;
  logic aw_full;
  logic w_full;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_wr;
  logic wr_hit;
  logic [1:0] wr_cmd;
  logic [1:0] wr_data;
  logic [1:0] soft_rst;
  logic rd_hit;
  logic [31:0] rd_word;

  // ==========================================================================
  // Input synchronisers
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_irq
      elg_sync_edge u_irq (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pin(irq_in[gi]),
        .level(),
        .rise(irq_rise[gi])
      );
    end
  endgenerate

  // The acknowledge pin is active low; it is inverted ahead of the first stage.
  elg_sync_edge u_ack (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin(!ack_chain_input_n),
    .level(ack_level),
    .rise(ack_start)
  );

  // ==========================================================================
  // Command decoder
  function automatic elg_pkg::elg_group_t apply_cmd(input elg_pkg::elg_group_t g, input logic [7:0] c);
    elg_pkg::elg_group_t r;
    logic [7:0] one;
    r = g;
    one = 8'h01 << c[`ELG_SEL_MSB:0];
    if (c == `ELG_SOFT_RESET_CMD) begin
      r.request_mask_reg = `ELG_MASK_RESET;
      r.request_latch_reg = `ELG_BYTE_ZERO;
      r.in_service_reg = `ELG_BYTE_ZERO;
      r.auto_clear_select_reg = `ELG_BYTE_ZERO;
    end else begin
      case (elg_pkg::elg_op_t'(c[`ELG_OP_MSB:`ELG_OP_LSB]))
        elg_pkg::ELG_OP_CLR_BOTH_ALL: begin
          r.request_mask_reg = `ELG_BYTE_ZERO;
          r.request_latch_reg = `ELG_BYTE_ZERO;
        end
        elg_pkg::ELG_OP_CLR_BOTH_ONE: begin
          r.request_mask_reg = g.request_mask_reg & ~one;
          r.request_latch_reg = g.request_latch_reg & ~one;
        end
        elg_pkg::ELG_OP_UNMASK_ALL: begin
          r.request_mask_reg = `ELG_BYTE_ZERO;
        end
        elg_pkg::ELG_OP_UNMASK_ONE: begin
          r.request_mask_reg = g.request_mask_reg & ~one;
        end
        elg_pkg::ELG_OP_MASK_ALL: begin
          r.request_mask_reg = `ELG_BYTE_ONES;
        end
        elg_pkg::ELG_OP_MASK_ONE: begin
          r.request_mask_reg = g.request_mask_reg | one;
        end
        elg_pkg::ELG_OP_DROP_ALL: begin
          r.request_latch_reg = `ELG_BYTE_ZERO;
        end
        elg_pkg::ELG_OP_DROP_ONE: begin
          r.request_latch_reg = g.request_latch_reg & ~one;
        end
        elg_pkg::ELG_OP_RAISE_ALL: begin
          r.request_latch_reg = `ELG_BYTE_ONES;
        end
        elg_pkg::ELG_OP_RAISE_ONE: begin
          r.request_latch_reg = g.request_latch_reg | one;
        end
        default: begin
          r = g;
        end
      endcase
    end
    return r;
  endfunction

  // ==========================================================================
  // Priority and fencing
  // Index 0 is group one level 0, the highest; index 15 is group two level 7.
  assign eff_arm[0] = group_arm_bit[0];
  assign eff_arm[1] = group_arm_bit[0] & group_arm_bit[1];
  assign service_all = {grp[1].in_service_reg, grp[0].in_service_reg};

  // A set service bit blocks its own level and every lower one, across both groups.
  always_comb begin
    fenced[0] = service_all[0];
    for (int i = 1; i < 16; i++) begin
      fenced[i] = fenced[i-1] | service_all[i];
    end
  end

  // Only levels above the highest service bit stay open, so a higher request nests.
  always_comb begin
    for (int g = 0; g < 2; g++) begin
      cand[g*8 +: 8] = grp[g].request_latch_reg & ~grp[g].request_mask_reg
        & {8{eff_arm[g]}} & ~fenced[g*8 +: 8];
    end
  end

  always_comb begin
    pick = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (cand[i]) begin
        pick = 4'(i);
      end
    end
  end

  // ==========================================================================
  // Acknowledge sequence
  // Candidates are those latched before the synchronised acknowledge edge.
  assign grant = (ack_state == elg_pkg::ELG_ACK_IDLE) && ack_start && (|cand);

  always_comb begin
    next_ack_state = ack_state;
    case (ack_state)
      elg_pkg::ELG_ACK_IDLE: begin
        if (ack_start) begin
          next_ack_state = (|cand) ? elg_pkg::ELG_ACK_GRANT : elg_pkg::ELG_ACK_PASS;
        end
      end
      elg_pkg::ELG_ACK_GRANT,
      elg_pkg::ELG_ACK_PASS: begin
        if (!ack_level) begin
          next_ack_state = elg_pkg::ELG_ACK_IDLE;
        end
      end
      default: begin
        next_ack_state = elg_pkg::ELG_ACK_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_state <= elg_pkg::ELG_ACK_IDLE;
    end else begin
      ack_state <= next_ack_state;
    end
  end

  // The answer holds the chosen group and level until the processor releases acknowledge.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_answer <= '0;
      ack_chain_pass <= 1'b0;
    end else begin
      if (grant) begin
        ack_answer.valid <= 1'b1;
        ack_answer.group <= pick[3];
        ack_answer.level <= pick[2:0];
      end else if (next_ack_state == elg_pkg::ELG_ACK_IDLE) begin
        ack_answer.valid <= 1'b0;
      end
      ack_chain_pass <= (next_ack_state == elg_pkg::ELG_ACK_PASS);
    end
  end

  // ==========================================================================
  // Group state
  // Order within one cycle: command, service clear, grant, then new edges, so a set wins.
  always_comb begin
    for (int g = 0; g < 2; g++) begin
      next_grp[g] = grp[g];
      if (wr_cmd[g]) begin
        next_grp[g] = apply_cmd(grp[g], w_data[7:0]);
      end
      if (wr_data[g]) begin
        next_grp[g].auto_clear_select_reg = w_data[7:0];
      end
      if (do_wr && wr_hit && (aw_addr == `ELG_SVC_CLR_OFS) && w_strb[g]) begin
        next_grp[g].in_service_reg = next_grp[g].in_service_reg & ~w_data[g*8 +: 8];
      end
      if (grant && (pick[3] == 1'(g))) begin
        next_grp[g].request_latch_reg[pick[2:0]] = 1'b0;
        if (!grp[g].auto_clear_select_reg[pick[2:0]]) begin
          next_grp[g].in_service_reg[pick[2:0]] = 1'b1;
        end
      end
      next_grp[g].request_latch_reg = next_grp[g].request_latch_reg | irq_rise[g*8 +: 8];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int g = 0; g < 2; g++) begin
        grp[g] <= '{in_service_reg: `ELG_BYTE_ZERO, auto_clear_select_reg: `ELG_BYTE_ZERO,
                    request_mask_reg: `ELG_MASK_RESET, request_latch_reg: `ELG_BYTE_ZERO};
      end
    end else begin
      for (int g = 0; g < 2; g++) begin
        grp[g] <= next_grp[g];
      end
    end
  end

  // Arming never writes the mask, so re-arming restores the old pattern.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      group_arm_bit <= 2'b00;
    end else begin
      for (int g = 0; g < 2; g++) begin
        if (soft_rst[g]) begin
          group_arm_bit[g] <= 1'b0;
        end else if (do_wr && wr_hit && (aw_addr == `ELG_ARM_OFS) && w_strb[0]) begin
          group_arm_bit[g] <= w_data[g];
        end
      end
    end
  end

  // Registered request; it follows the candidates one edge later.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      group_request_output <= 1'b0;
    end else begin
      group_request_output <= |cand;
    end
  end

  // ==========================================================================
  // AXI4-Lite write channel
  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready = !w_full && !s_axi_bvalid;
  assign do_wr = aw_full && w_full && !s_axi_bvalid;

  always_comb begin
    case (aw_addr)
      `ELG_G1_CMD_OFS, `ELG_G1_DATA_OFS, `ELG_G2_CMD_OFS, `ELG_G2_DATA_OFS,
      `ELG_ARM_OFS, `ELG_SVC_CLR_OFS, `ELG_ACK_STAT_OFS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Commands take only the low byte lane.
  assign wr_cmd[0] = do_wr && (aw_addr == `ELG_G1_CMD_OFS) && w_strb[0];
  assign wr_cmd[1] = do_wr && (aw_addr == `ELG_G2_CMD_OFS) && w_strb[0];
  assign wr_data[0] = do_wr && (aw_addr == `ELG_G1_DATA_OFS) && w_strb[0];
  assign wr_data[1] = do_wr && (aw_addr == `ELG_G2_DATA_OFS) && w_strb[0];
  assign soft_rst[0] = wr_cmd[0] && (w_data[7:0] == `ELG_SOFT_RESET_CMD);
  assign soft_rst[1] = wr_cmd[1] && (w_data[7:0] == `ELG_SOFT_RESET_CMD);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_full <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_wr) begin
      aw_full <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      w_full <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_wr) begin
      w_full <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ELG_RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `ELG_RESP_OKAY : `ELG_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel
  // Command ports and the service clear port are write-only and read as zero.
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rd_hit = 1'b1;
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      `ELG_G1_CMD_OFS, `ELG_G2_CMD_OFS, `ELG_SVC_CLR_OFS: rd_word = 32'h0000_0000;
      `ELG_G1_DATA_OFS: rd_word = grp[0];
      `ELG_G2_DATA_OFS: rd_word = grp[1];
      `ELG_ARM_OFS: rd_word = {30'h0000_0000, group_arm_bit};
      `ELG_ACK_STAT_OFS: rd_word = {22'h00_0000, ack_state, group_request_output, ack_chain_pass,
                                    1'b0, ack_answer};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `ELG_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? `ELG_RESP_OKAY : `ELG_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // elg_irq_groups

// file: testbench/elg_irq_chk.sv
/*
  Checker for the interrupt group block: write answers, arm gating, command effects, acknowledge.
  Assumes it is bound to elg_irq_groups and that writes offer address and data together.
*/
`timescale 1ns/1ps
module elg_irq_chk (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ack_chain_input_n,
  input wire logic group_request_output,
  input wire logic ack_chain_pass,
  input wire elg_pkg::elg_ack_t ack_answer,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid
);
  logic wr_go;
  logic g1_cmd;
  logic arm_q;
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign g1_cmd = wr_go && s_axi_wstrb[0] && s_axi_awaddr == 8'h00;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // ==========
  // Group one arm as last written; it leads the block by one edge, so checks allow slack.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      arm_q <= 1'b0;
    end else if (wr_go && s_axi_wstrb[0] && s_axi_awaddr == 8'h10) begin
      arm_q <= s_axi_wdata[0];
    end else if (g1_cmd && s_axi_wdata[7:0] == 8'h00) begin
      arm_q <= 1'b0;
    end
  end
  // ==========
  // Assertions
  property p_wr_ans;
    wr_go |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer missing");
  property p_bad_addr;
    wr_go && s_axi_awaddr > 8'h18 |-> ##2 s_axi_bvalid && s_axi_bresp == 2'b10;
  endproperty
  a_bad_addr: assert property (p_bad_addr) else $error("unmapped write not refused");
  property p_disarm;
    !arm_q [*3] |-> !group_request_output;
  endproperty
  a_disarm: assert property (p_disarm) else $error("request while disarmed");
  property p_mask_all;
    g1_cmd && s_axi_wdata[7:3] == 5'b00110 |-> ##3 !group_request_output [*3];
  endproperty
  a_mask_all: assert property (p_mask_all) else $error("request after mask all");
  property p_drop_all;
    g1_cmd && s_axi_wdata[7:3] == 5'b01000 |-> ##3 !group_request_output;
  endproperty
  a_drop_all: assert property (p_drop_all) else $error("request after latch clear");
  property p_clr_both;
    g1_cmd && s_axi_wdata[7:3] == 5'b00010 |-> ##3 !group_request_output;
  endproperty
  a_clr_both: assert property (p_clr_both) else $error("request after mask and latch clear");
  property p_soft_rst;
    g1_cmd && s_axi_wdata[7:0] == 8'h00 |-> ##3 !group_request_output [*5];
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("request after soft reset");
  property p_ack_ans;
    $fell(ack_chain_input_n) |-> ##[1:8] (ack_answer.valid || ack_chain_pass);
  endproperty
  a_ack_ans: assert property (p_ack_ans) else $error("acknowledge not answered");
endmodule // elg_irq_chk

bind elg_irq_groups elg_irq_chk u_chk (
  .core_clk, .rst_n, .ack_chain_input_n, .group_request_output, .ack_chain_pass, .ack_answer,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid
);

// file: testbench/elg_cpu_model.sv
/*
  Processor model: answers a raised request with an acknowledge cycle after a set lag.
  Assumes the block's clock; the bench enables it and reads the captured answer.
*/
`timescale 1ns/1ps
module elg_cpu_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic [3:0] lag,
  input wire logic group_request_output,
  input wire logic ack_chain_pass,
  input wire elg_pkg::elg_ack_t ack_answer,
  output logic ack_chain_input_n,
  output elg_pkg::elg_ack_t got,
  output int ack_count
);
  int i;
  // ==========
  // Acknowledge cycle
  // The acknowledge is held until the block answers or 40 cycles pass, so only a grant slower than that is cut short.
  initial begin
    ack_chain_input_n = 1'b1;
    got = '0;
    ack_count = 0;
    forever begin
      @(posedge core_clk);
      if (rst_n && en && group_request_output) begin
        repeat (lag) @(posedge core_clk);
        ack_chain_input_n <= 1'b0;
        for (i = 0; i < 40 && !(ack_answer.valid || ack_chain_pass); i++) @(posedge core_clk);
        got <= ack_answer;
        ack_count <= ack_count + 1;
        ack_chain_input_n <= 1'b1;
        for (i = 0; i < 40 && (ack_answer.valid || ack_chain_pass); i++) @(posedge core_clk);
      end
    end
  end
endmodule // elg_cpu_model

// file: testbench/eight_level_irq_group_cmd_test.sv
/*
  Self-checking bench for the interrupt group block: registers, commands, arm gating, acknowledge.
  Assumes elg_pkg, the processor model and the bound checker are compiled before it.
*/
`timescale 1ns/1ps
module eight_level_irq_group_cmd_test;
  logic core_clk;
  logic rst_n;
  logic [15:0] irq_in;
  logic ack_chain_input_n;
  logic group_request_output;
  logic ack_chain_pass;
  elg_pkg::elg_ack_t ack_answer;
  elg_pkg::elg_ack_t got;
  logic [7:0] s_axi_awaddr;
  logic s_axi_awvalid;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_wvalid;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready;
  logic [7:0] s_axi_araddr;
  logic s_axi_arvalid;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready;
  logic [1:0] b_last;
  logic [1:0] r_last;
  logic en;
  logic [3:0] lag;
  int ack_count;
  int n_errors;
  int n_checks;
  // Each row, run after a soft reset: first command, second command, then the expected mask and latch after both commands.
  localparam logic [31:0] cmd_tbl [10] = '{
    32'h5012_0000,
    32'h5D1D_DF00,
    32'h5027_00FF,
    32'h502B_F7FF,
    32'h2035_FF00,
    32'h203E_4000,
    32'h5043_FF00,
    32'h504F_FF7F,
    32'h5B08_FF08,
    32'h5000_FF00};
  localparam logic [7:0] out_tbl [8] = '{8'h50, 8'h30, 8'h20, 8'h40, 8'h50, 8'h10, 8'h50, 8'h00};

  elg_irq_groups DUT (.core_clk, .rst_n, .irq_in, .ack_chain_input_n, .group_request_output, .ack_chain_pass,
    .ack_answer, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  elg_cpu_model u_cpu (.core_clk, .rst_n, .en, .lag, .group_request_output, .ack_chain_pass, .ack_answer,
    .ack_chain_input_n, .got, .ack_count);

  // ==========
  // Shared tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic test_done;
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic lim(input logic over);
    chk({31'h0, over}, 32'h0);
    if (over) test_done();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (k = 0; k < 50 && (k == 0 || s_axi_awvalid || s_axi_wvalid); k++) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    lim(k == 50);
    for (k = 0; k < 50 && !s_axi_bvalid; k++) @(posedge core_clk);
    lim(k == 50);
    b_last = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int k;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (k = 0; k < 50 && (k == 0 || s_axi_arvalid); k++) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    lim(k == 50);
    for (k = 0; k < 50 && !s_axi_rvalid; k++) @(posedge core_clk);
    lim(k == 50);
    d = s_axi_rdata;
    r_last = s_axi_rresp;
  endtask
  task automatic wait_out(input logic e);
    int k;
    for (k = 0; k < 20 && group_request_output !== e; k++) @(posedge core_clk);
    lim(k == 20);
  endtask
  task automatic hold_out(input logic e);
    logic bad;
    bad = 1'b0;
    repeat (12) begin
      @(posedge core_clk);
      bad = bad | (group_request_output !== e);
    end
    chk({31'h0, bad}, 32'h0);
  endtask
  task automatic wait_ack(input int n, input logic [4:0] e);
    int k;
    for (k = 0; k < 200 && ack_count < n; k++) @(posedge core_clk);
    lim(k == 200);
    chk({27'h0, got}, {27'h0, e});
  endtask

  // ==========
  // Scenarios
  task automatic t_bus;
    logic [31:0] d;
    rd(8'h04, d);
    chk(d, 32'h0000_FF00);
    rd(8'h0C, d);
    chk(d, 32'h0000_FF00);
    wr(8'h1C, 32'h0000_0000);
    chk({30'h0, b_last}, 32'h2);
    rd(8'h1C, d);
    chk({r_last, d[29:0]}, 32'h8000_0000);
  endtask
  task automatic t_cmds;
    logic [31:0] d;
    logic [7:0] g;
    for (int i = 0; i < 20; i++) begin
      g = (i < 10) ? 8'h00 : 8'h08;
      wr(g, 32'h0000_0000);
      wr(g, {24'h0, cmd_tbl[i % 10][31:24]});
      wr(g, {24'h0, cmd_tbl[i % 10][23:16]});
      rd(g + 8'h04, d);
      chk(d, {16'h0, cmd_tbl[i % 10][15:0]});
    end
  endtask
  task automatic t_arm;
    logic [31:0] d;
    wr(8'h00, 32'h0000_0000);
    wr(8'h08, 32'h0000_0000);
    wr(8'h00, 32'h0000_0020);
    irq_in[5] <= 1'b1;
    repeat (4) @(posedge core_clk);
    irq_in[5] <= 1'b0;
    hold_out(1'b0);
    rd(8'h04, d);
    chk(d, 32'h0000_0020);
    wr(8'h10, 32'h0000_0001);
    wait_out(1'b1);
    wr(8'h00, 32'h0000_003D);
    wait_out(1'b0);
    wr(8'h00, 32'h0000_002D);
    wait_out(1'b1);
    wr(8'h10, 32'h0000_0000);
    wait_out(1'b0);
    wr(8'h10, 32'h0000_0001);
    wait_out(1'b1);
    wr(8'h08, 32'h0000_0020);
    wr(8'h08, 32'h0000_0058);
    wr(8'h10, 32'h0000_0002);
    hold_out(1'b0);
    wr(8'h10, 32'h0000_0003);
    wait_out(1'b1);
  endtask
  task automatic t_ack;
    logic [31:0] d;
    en <= 1'b1;
    wait_ack(1, 5'b1_0_101);
    rd(8'h04, d);
    chk(d, 32'h2000_0000);
    hold_out(1'b0);
    lag <= 4'h9;
    wr(8'h00, 32'h0000_005A);
    wait_ack(2, 5'b1_0_010);
    wr(8'h14, 32'h0000_0024);
    wait_ack(3, 5'b1_1_000);
    en <= 1'b0;
  endtask
  // The request is withdrawn during the processor's lag, so the acknowledge finds nothing to grant.
  task automatic t_pass;
    int k;
    logic [31:0] d;
    wr(8'h00, 32'h0000_005B);
    wait_out(1'b1);
    en <= 1'b1;
    repeat (3) @(posedge core_clk);
    wr(8'h00, 32'h0000_004B);
    wait_out(1'b0);
    for (k = 0; k < 40 && !ack_chain_pass; k++) @(posedge core_clk);
    lim(k == 40);
    rd(8'h18, d);
    chk(d & 32'h0000_03F0, 32'h0000_0240);
    en <= 1'b0;
  endtask
  task automatic t_out;
    for (int i = 0; i < 8; i++) begin
      wr(8'h00, {24'h0, out_tbl[i]});
      wait_out(!i[0]);
    end
  endtask

  // ==========
  // Clock, reset and sequence
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    rst_n = 1'b0;
    irq_in = 16'h0000;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b1;
    en = 1'b0;
    lag = 4'h0;
    n_errors = 0;
    n_checks = 0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_bus();
    t_cmds();
    t_arm();
    t_ack();
    t_pass();
    t_out();
    test_done();
  end
endmodule // eight_level_irq_group_cmd_test
